// [prb_regs.sv]
// Notes on behaviour
// - each register is one 16-bit word
// - reserved bits read zero
// - port1 direction is scratch, no pin effect
// - every access runs external cycle, no selects
// - read data ignores external address/data bus
// - zero wait states except timer compare and count
// - timer compare and count take exactly one wait
// - mask write updates source control mask bits
// - timer compare and count not reset
// - only port2 direction bits 6,7 act
// - other direction bits are plain latches
// - latches hold 8 bits, outputs drive only
// - serial transmit and receive buffers read/write
// - status read clears flags except clear-to-send
// - refresh address read returns current address
// - refresh address write sets next address
// - readable stepping identifier, value unreliable
`timescale 1ns/1ps
`default_nettype none
`include "prb_params.svh"

module prb_regs
    import prb_pkg::*;
#(
    parameter logic [15:0] STEP_ID = 16'h0005 // arbitrary value
)(
    input  wire logic        I_CLK,          // processor clock
    input  wire logic        I_RST_N,        // async reset, active low
    input  wire logic        i_req,          // access request pulse
    input  wire logic        i_wr,           // 1 write, 0 read
    input  wire logic [7:0]  i_addr,         // byte offset in block
    input  wire logic [15:0] i_wdata,        // write data
    input  wire logic [15:0] i_ext_ad,       // external bus data, unused
    input  wire logic        i_cts,          // clear-to-send pin
    input  wire logic [2:0]  i_ser_evt,      // serial flag set pulses
    input  wire logic        i_rx_valid,     // receive byte strobe
    input  wire logic [7:0]  i_rx_data,      // received byte
    input  wire logic        i_refresh_done, // refresh cycle finished
    output logic             o_ack,          // access complete pulse
    output logic [15:0]      o_rdata,        // read data at ack
    output logic             o_ext_cycle,    // external cycle running
    output logic             o_cs_inhibit,   // chip selects held off
    output logic [7:0]       o_port1_out,    // port1 pin drive
    output logic [7:0]       o_port2_out,    // port2 pin drive
    output logic [7:0]       o_port2_oe,     // port2 output enables
    output logic [1:0]       o_src_mask,     // timer, serial masks
    output logic [7:0]       o_tx_data,      // transmit buffer
    output logic             o_tx_start,     // transmit buffer written
    output logic [15:0]      o_refresh_addr, // next refresh address
    output logic [15:0]      o_timer_cmp,    // timer compare
    output logic [15:0]      o_timer_cnt     // timer count
);

    ////////////////////////////////////////////////////////////////////////
    // reset release and synchronisers

    logic rst_s1_q;
    logic rst_n_q;
    logic cts_s1_q;
    logic cts_q;

    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    always_ff @(posedge I_CLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            cts_s1_q <= 1'b0;
            cts_q    <= 1'b0;
        end
        else
        begin
            cts_s1_q <= i_cts;
            cts_q    <= cts_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // access sequencer

    function automatic logic is_timer(input logic [7:0] a);
        is_timer = (a == `PRB_OFS_TIMER_CMP) || (a == `PRB_OFS_TIMER_CNT);
    endfunction

    prb_state_t state_q;
    prb_state_t state_d;
    prb_req_t   req_q;
    logic       take;
    logic       act;
    logic       act_wr;
    logic       act_rd;

    assign take   = (state_q == PRB_IDLE) && i_req;
    assign act    = (state_q == PRB_ACCESS);
    assign act_wr = act && req_q.wr;
    assign act_rd = act && !req_q.wr;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            PRB_IDLE:
            begin
                if (i_req)
                begin
                    // timer side needs a sync cycle before the access lands
                    state_d = (is_timer(i_addr) && `PRB_TIMER_WAITS) ? PRB_WAIT : PRB_ACCESS;
                end
            end
            PRB_WAIT:   state_d = PRB_ACCESS;
            PRB_ACCESS: state_d = PRB_IDLE;
            default:    state_d = PRB_IDLE;
        endcase
    end

    always_ff @(posedge I_CLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            state_q      <= PRB_IDLE;
            req_q        <= '0;
            o_ext_cycle  <= 1'b0;
            o_cs_inhibit <= 1'b0;
            o_ack        <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            if (take)
            begin
                req_q <= '{wr: i_wr, addr: i_addr, wdata: i_wdata};
            end
            // mirror cycle on the pins, selects kept off for the whole cycle
            o_ext_cycle  <= (state_d != PRB_IDLE);
            o_cs_inhibit <= (state_d != PRB_IDLE);
            o_ack        <= act;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // address decode

    logic h_mask;
    logic h_tctl;
    logic h_sctl;
    logic h_cmp;
    logic h_cnt;
    logic h_p1d;
    logic h_p1l;
    logic h_p2d;
    logic h_p2l;
    logic h_tx;
    logic h_rx;
    logic h_sts;
    logic h_rfa;
    logic h_step;

    assign h_mask = (req_q.addr == `PRB_OFS_MASK);
    assign h_tctl = (req_q.addr == `PRB_OFS_TIMER_CTL);
    assign h_sctl = (req_q.addr == `PRB_OFS_SER_CTL);
    assign h_cmp  = (req_q.addr == `PRB_OFS_TIMER_CMP);
    assign h_cnt  = (req_q.addr == `PRB_OFS_TIMER_CNT);
    assign h_p1d  = (req_q.addr == `PRB_OFS_P1_DIR);
    assign h_p1l  = (req_q.addr == `PRB_OFS_P1_LATCH);
    assign h_p2d  = (req_q.addr == `PRB_OFS_P2_DIR);
    assign h_p2l  = (req_q.addr == `PRB_OFS_P2_LATCH);
    assign h_tx   = (req_q.addr == `PRB_OFS_SER_TX);
    assign h_rx   = (req_q.addr == `PRB_OFS_SER_RX);
    assign h_sts  = (req_q.addr == `PRB_OFS_SER_STS);
    assign h_rfa  = (req_q.addr == `PRB_OFS_REFRESH);
    assign h_step = (req_q.addr == `PRB_OFS_STEP_ID);

    ////////////////////////////////////////////////////////////////////////
    // register storage

    logic [`PRB_CTL_MSB:0] tctl_q;
    logic [`PRB_CTL_MSB:0] sctl_q;
    logic [7:0]            port1_dir_q;
    logic [7:0]            port2_dir_q;
    logic [7:0]            p1lat_q;
    logic [7:0]            p2lat_q;
    logic [7:0]            rx_q;
    logic [2:0]            sts_q;
    logic [2:0]            sts_d;
    logic [15:0]           rfa_d;

    // interrupt mask has no storage of its own: it is the mask bits
    // of the source control words, so both views always agree
    logic [`PRB_CTL_MSB:0] tctl_d;
    logic [`PRB_CTL_MSB:0] sctl_d;

    always_comb
    begin
        tctl_d = tctl_q;
        sctl_d = sctl_q;
        if (act_wr && h_tctl)
        begin
            tctl_d = req_q.wdata[`PRB_CTL_MSB:0];
        end
        if (act_wr && h_sctl)
        begin
            sctl_d = req_q.wdata[`PRB_CTL_MSB:0];
        end
        if (act_wr && h_mask)
        begin
            tctl_d[`PRB_CTL_MASK_BIT] = req_q.wdata[`PRB_MASK_TIMER_BIT];
            sctl_d[`PRB_CTL_MASK_BIT] = req_q.wdata[`PRB_MASK_SER_BIT];
        end
    end

    // a flag raised in the clearing cycle survives the clear
    assign sts_d = ((act_rd && h_sts) ? `PRB_STS_RST : sts_q) | i_ser_evt;

    // software write beats the refresh unit's own step
    assign rfa_d = (act_wr && h_rfa) ? req_q.wdata :
                   i_refresh_done ? (o_refresh_addr + 16'h0001) : o_refresh_addr;

    always_ff @(posedge I_CLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            tctl_q         <= `PRB_CTL_RST;
            sctl_q         <= `PRB_CTL_RST;
            port1_dir_q    <= `PRB_DIR_RST;
            port2_dir_q    <= `PRB_DIR_RST;
            p1lat_q        <= `PRB_BYTE_RST;
            p2lat_q        <= `PRB_BYTE_RST;
            rx_q           <= `PRB_BYTE_RST;
            o_tx_data      <= `PRB_BYTE_RST;
            o_tx_start     <= 1'b0;
            sts_q          <= `PRB_STS_RST;
            o_refresh_addr <= `PRB_WORD_RST;
        end
        else
        begin
            tctl_q         <= tctl_d;
            sctl_q         <= sctl_d;
            sts_q          <= sts_d;
            o_refresh_addr <= rfa_d;
            o_tx_start     <= act_wr && h_tx;
            if (act_wr && h_p1d)
            begin
                port1_dir_q <= req_q.wdata[7:0];
            end
            if (act_wr && h_p2d)
            begin
                port2_dir_q <= req_q.wdata[7:0];
            end
            if (act_wr && h_p1l)
            begin
                p1lat_q <= req_q.wdata[7:0];
            end
            if (act_wr && h_p2l)
            begin
                p2lat_q <= req_q.wdata[7:0];
            end
            if (act_wr && h_tx)
            begin
                o_tx_data <= req_q.wdata[7:0];
            end
            if (act_wr && h_rx)
            begin
                rx_q <= req_q.wdata[7:0];
            end
            else if (i_rx_valid)
            begin
                rx_q <= i_rx_data;
            end
        end
    end

    // compare and count keep whatever they power up with
    always_ff @(posedge I_CLK)
    begin
        if (act_wr && h_cmp)
        begin
            o_timer_cmp <= req_q.wdata;
        end
        if (act_wr && h_cnt)
        begin
            o_timer_cnt <= req_q.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin side

    always_ff @(posedge I_CLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            o_port1_out <= `PRB_BYTE_RST;
            o_port2_out <= `PRB_BYTE_RST;
            o_port2_oe  <= `PRB_BYTE_RST;
            o_src_mask  <= `PRB_MASK_RST;
        end
        else
        begin
            // port1 is output only whatever its direction latch holds
            o_port1_out <= p1lat_q;
            o_port2_out <= p2lat_q & `PRB_P2_PIN_MASK;
            o_port2_oe  <= {~port2_dir_q[`PRB_P2_DIR_HI], ~port2_dir_q[`PRB_P2_DIR_LO], 6'h00};
            o_src_mask  <= {sctl_q[`PRB_CTL_MASK_BIT], tctl_q[`PRB_CTL_MASK_BIT]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux: reserved bits and unmapped offsets read zero,
    // the external bus value never enters here

    logic [15:0] rd_mux;

    assign rd_mux = h_mask ? {14'h0000, sctl_q[`PRB_CTL_MASK_BIT], tctl_q[`PRB_CTL_MASK_BIT]} :
                    h_tctl ? {12'h000, tctl_q} :
                    h_sctl ? {12'h000, sctl_q} :
                    h_cmp  ? o_timer_cmp :
                    h_cnt  ? o_timer_cnt :
                    h_p1d  ? {8'h00, port1_dir_q} :
                    h_p1l  ? {8'h00, p1lat_q} :
                    h_p2d  ? {8'h00, port2_dir_q} :
                    h_p2l  ? {8'h00, p2lat_q} :
                    h_tx   ? {8'h00, o_tx_data} :
                    h_rx   ? {8'h00, rx_q} :
                    h_sts  ? {11'h000, cts_q, 1'b0, sts_q} :
                    h_rfa  ? o_refresh_addr :
                    h_step ? STEP_ID :
                    16'h0000;

    always_ff @(posedge I_CLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            o_rdata <= `PRB_WORD_RST;
        end
        else if (act_rd)
        begin
            o_rdata <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_plain_wait_none: assert property (@(posedge I_CLK) disable iff (!rst_n_q)
        take && !is_timer(i_addr) |=> !o_ack ##1 o_ack)
        else $error("plain register access not acked after two edges");

    a_timer_wait_one: assert property (@(posedge I_CLK) disable iff (!rst_n_q)
        take && is_timer(i_addr) |=> !o_ack [*2] ##1 o_ack)
        else $error("timer access did not take one wait state");

    a_cs_held_off: assert property (@(posedge I_CLK) disable iff (!rst_n_q)
        take |=> (o_ext_cycle && o_cs_inhibit) ##1 (o_ack || (o_ext_cycle && o_cs_inhibit)))
        else $error("external cycle or select inhibit dropped early");

    a_mask_mirror_bits: assert property (@(posedge I_CLK) disable iff (!rst_n_q)
        act_wr && h_mask |=> ##1 o_src_mask == $past(req_q.wdata[1:0], 2))
        else $error("mask write not mirrored into control words");

    a_status_read_clr: assert property (@(posedge I_CLK) disable iff (!rst_n_q)
        act_rd && h_sts |=> sts_q == $past(i_ser_evt))
        else $error("status read left stale flags or lost an event");

    a_status_read_cts: assert property (@(posedge I_CLK) disable iff (!rst_n_q)
        act_rd && h_sts |=> o_rdata[`PRB_STS_CTS_BIT] == $past(cts_q))
        else $error("clear-to-send bit not from synchronised pin");

    a_port2_dir_only: assert property (@(posedge I_CLK) disable iff (!rst_n_q)
        ##1 o_port2_oe[5:0] == 6'h00 && o_port2_oe[7:6] == ~$past(port2_dir_q[7:6]))
        else $error("port2 enable not from direction bits 6 and 7");

    a_refresh_write_set: assert property (@(posedge I_CLK) disable iff (!rst_n_q)
        act_wr && h_rfa |=> o_refresh_addr == $past(req_q.wdata))
        else $error("refresh address write not taken");

    a_refresh_read_cur: assert property (@(posedge I_CLK) disable iff (!rst_n_q)
        act_rd && h_rfa |=> o_rdata == $past(o_refresh_addr))
        else $error("refresh address read not current value");

    a_port1_direction_scratch: assert property (@(posedge I_CLK) disable iff (!rst_n_q)
        act_rd && h_p1d |=> o_rdata == {8'h00, $past(port1_dir_q)})
        else $error("port1 direction read does not return stored byte");

endmodule
`default_nettype wire

// [prb_params.svh]
`ifndef PRB_PARAMS_SVH
`define PRB_PARAMS_SVH
// register offsets inside the block (byte addresses)
`define PRB_OFS_MASK      8'h08
`define PRB_OFS_TIMER_CTL 8'h12
`define PRB_OFS_SER_CTL   8'h14
`define PRB_OFS_TIMER_CMP 8'h30
`define PRB_OFS_TIMER_CNT 8'h32
`define PRB_OFS_P1_DIR    8'h50
`define PRB_OFS_P1_LATCH  8'h52
`define PRB_OFS_P2_DIR    8'h54
`define PRB_OFS_P2_LATCH  8'h56
`define PRB_OFS_SER_TX    8'h60
`define PRB_OFS_SER_RX    8'h62
`define PRB_OFS_SER_STS   8'h64
`define PRB_OFS_REFRESH   8'h70
`define PRB_OFS_STEP_ID   8'h7e
// field layout
`define PRB_MASK_TIMER_BIT 0
`define PRB_MASK_SER_BIT  1
`define PRB_CTL_MSB       3
`define PRB_CTL_MASK_BIT  3
`define PRB_STS_RX_BIT    0
`define PRB_STS_TX_BIT    1
`define PRB_STS_ERR_BIT   2
`define PRB_STS_CTS_BIT   4
`define PRB_P2_DIR_LO     6
`define PRB_P2_DIR_HI     7
`define PRB_P2_PIN_MASK   8'hc0
// reset values
`define PRB_CTL_RST       4'hf
`define PRB_BYTE_RST      8'h00
`define PRB_DIR_RST       8'hff
`define PRB_WORD_RST      16'h0000
`define PRB_STS_RST       3'h0
`define PRB_MASK_RST      2'h3
// wait states
`define PRB_TIMER_WAITS   1'b1
`endif

// [prb_pkg.sv]
`default_nettype none
package prb_pkg;
    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } prb_req_t;

    typedef enum logic [1:0] {
        PRB_IDLE,
        PRB_WAIT,
        PRB_ACCESS
    } prb_state_t;
endpackage
`default_nettype wire

// [prb_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module prb_core_model
    import prb_pkg::*;
(
    input  wire logic        i_clk,    // processor clock
    input  wire logic        i_ack,    // access done pulse
    input  wire logic [15:0] i_rdata,  // read data
    input  wire logic        i_ext,    // external cycle running
    input  wire logic        i_csinh,  // chip selects held off
    output logic             o_req,    // request pulse
    output prb_req_t         o_cmd,    // write flag, offset, data
    output logic [15:0]      o_ext_ad  // foreign bus value
);
    initial
    begin
        o_req    = 1'b0;
        o_cmd    = '0;
        o_ext_ad = 16'h5a5a;
    end

    // bus content changes each cycle so a leak into read data shows up
    always @(negedge i_clk)
        o_ext_ad <= ~o_ext_ad + 16'h0001;

    // caller is at a falling edge; returning at the ack cycle allows back to back
    task automatic access(input logic wr, input logic [7:0] addr, input logic [15:0] wdata,
                          output logic [15:0] rdata, output int n, output int n_ext);
        n     = 0;
        n_ext = 0;
        o_req = 1'b1;
        o_cmd = '{wr, addr, wdata};
        while (n < 8)
        begin
            @(negedge i_clk);
            o_req       = 1'b0;
            o_cmd.wdata = ~wdata;
            n++;
            if (i_ext === 1'b1 && i_csinh === 1'b1)
                n_ext++;
            if (i_ack === 1'b1)
                break;
        end
        rdata = i_rdata;
    endtask
endmodule
`default_nettype wire

// [tb_prb_regs.sv]
`timescale 1ns/1ps
`default_nettype none
`include "prb_params.svh"
module tb_prb_regs;
    import prb_pkg::*;
    localparam logic [15:0] STEP_VAL = 16'h00a5; // arbitrary value
    localparam logic [7:0] OFS [14] = '{`PRB_OFS_MASK, `PRB_OFS_TIMER_CTL, `PRB_OFS_SER_CTL, `PRB_OFS_TIMER_CMP,
        `PRB_OFS_TIMER_CNT, `PRB_OFS_P1_DIR, `PRB_OFS_P1_LATCH, `PRB_OFS_P2_DIR, `PRB_OFS_P2_LATCH,
        `PRB_OFS_SER_TX, `PRB_OFS_SER_RX, `PRB_OFS_SER_STS, `PRB_OFS_REFRESH, `PRB_OFS_STEP_ID};
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cts = 1'b0;
    logic [2:0]  ser_evt = 3'h0;
    logic        rx_valid = 1'b0;
    logic [7:0]  rx_data = 8'h00;
    logic        refresh_done = 1'b0;
    wire         req, ack, ext_cycle, cs_inhibit, tx_start;
    prb_req_t    cmd;
    wire [15:0]  ext_ad, rdata, refresh_addr, timer_cmp, timer_cnt;
    wire [7:0]   port1_out, port2_out, port2_oe, tx_data;
    wire [1:0]   src_mask;
    logic [15:0] rd_q;
    int          n_cyc, n_ext, failures = 0, n_checks = 0;

    always #10 clk = ~clk;

    prb_regs #(.STEP_ID(STEP_VAL)) u_prb_regs (
        .I_CLK(clk), .I_RST_N(rst_n), .i_req(req), .i_wr(cmd.wr), .i_addr(cmd.addr),
        .i_wdata(cmd.wdata), .i_ext_ad(ext_ad), .i_cts(cts), .i_ser_evt(ser_evt),
        .i_rx_valid(rx_valid), .i_rx_data(rx_data), .i_refresh_done(refresh_done),
        .o_ack(ack), .o_rdata(rdata), .o_ext_cycle(ext_cycle), .o_cs_inhibit(cs_inhibit),
        .o_port1_out(port1_out), .o_port2_out(port2_out), .o_port2_oe(port2_oe),
        .o_src_mask(src_mask), .o_tx_data(tx_data), .o_tx_start(tx_start),
        .o_refresh_addr(refresh_addr), .o_timer_cmp(timer_cmp), .o_timer_cnt(timer_cnt));

    prb_core_model u_prb_core_model (
        .i_clk(clk), .i_ack(ack), .i_rdata(rdata), .i_ext(ext_cycle), .i_csinh(cs_inhibit),
        .o_req(req), .o_cmd(cmd), .o_ext_ad(ext_ad));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp);
        n_checks++;
        if (got != exp)
        begin
            failures++;
            $display("unexpected at %0t: count %0d, wanted %0d", $time, got, exp);
        end
    endtask

    // reserved bits always written as zero by these callers
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        u_prb_core_model.access(1'b1, a, d, rd_q, n_cyc, n_ext);
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        u_prb_core_model.access(1'b0, a, 16'h0000, rd_q, n_cyc, n_ext);
        chk_word(rd_q, e);
    endtask

    task automatic end_sim;
        $display("checks %0d, failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_vals;
        rd(`PRB_OFS_MASK, 16'h0003);
        chk_word({14'h0000, src_mask}, 16'h0003);
        rd(`PRB_OFS_P2_DIR, 16'h00ff);
        chk_word({8'h00, port2_oe}, 16'h0000);
        rd(`PRB_OFS_STEP_ID, STEP_VAL);
        rd(8'h40, 16'h0000);
    endtask

    task automatic t_waits;
        wr(`PRB_OFS_TIMER_CMP, 16'h1234);
        chk_cnt(n_cyc, 3);
        wr(`PRB_OFS_TIMER_CNT, 16'h5678);
        chk_cnt(n_cyc, 3);
        for (int i = 0; i < 14; i++)
        begin
            u_prb_core_model.access(1'b0, OFS[i], 16'h0000, rd_q, n_cyc, n_ext);
            chk_cnt(n_cyc, (OFS[i] == `PRB_OFS_TIMER_CMP || OFS[i] == `PRB_OFS_TIMER_CNT) ? 3 : 2);
            chk_cnt(n_ext, n_cyc - 1);
        end
        rd(`PRB_OFS_TIMER_CMP, 16'h1234);
        chk_word(timer_cmp, 16'h1234);
        chk_word(timer_cnt, 16'h5678);
    endtask

    task automatic t_ports;
        wr(`PRB_OFS_P1_LATCH, 16'h00a5);
        wr(`PRB_OFS_P1_DIR, 16'h0000);
        @(negedge clk);
        chk_word({8'h00, port1_out}, 16'h00a5);
        rd(`PRB_OFS_P1_DIR, 16'h0000);
        rd(`PRB_OFS_P1_LATCH, 16'h00a5);
        wr(`PRB_OFS_P2_DIR, 16'h003f);
        wr(`PRB_OFS_P2_LATCH, 16'h00c3);
        @(negedge clk);
        chk_word({port2_oe, port2_out}, 16'hc0c0);
        rd(`PRB_OFS_P2_DIR, 16'h003f);
        rd(`PRB_OFS_P2_LATCH, 16'h00c3);
        wr(`PRB_OFS_P2_DIR, 16'h00bf);
        @(negedge clk);
        chk_word({8'h00, port2_oe}, 16'h0040);
    endtask

    task automatic t_mask;
        wr(`PRB_OFS_MASK, 16'h0000);
        @(negedge clk);
        chk_word({14'h0000, src_mask}, 16'h0000);
        wr(`PRB_OFS_MASK, 16'h0001);
        rd(`PRB_OFS_TIMER_CTL, 16'h000f);
        rd(`PRB_OFS_SER_CTL, 16'h0007);
        chk_word({14'h0000, src_mask}, 16'h0001);
    endtask

    // second reset mid-run: timer values must survive it
    task automatic t_timer_keep;
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        chk_word(timer_cmp, 16'h1234);
        chk_word(timer_cnt, 16'h5678);
        rd(`PRB_OFS_TIMER_CMP, 16'h1234);
        rd(`PRB_OFS_MASK, 16'h0003);
    endtask

    task automatic t_serial;
        wr(`PRB_OFS_SER_TX, 16'h0077);
        chk_word({7'h00, tx_start, tx_data}, 16'h0177);
        @(negedge clk);
        chk_word({7'h00, tx_start, tx_data}, 16'h0077);
        rd(`PRB_OFS_SER_TX, 16'h0077);
        wr(`PRB_OFS_SER_RX, 16'h0011);
        rd(`PRB_OFS_SER_RX, 16'h0011);
        rx_data = 8'h99;
        rx_valid = 1'b1;
        @(negedge clk);
        rx_valid = 1'b0;
        rd(`PRB_OFS_SER_RX, 16'h0099);
    endtask

    task automatic t_status;
        cts = 1'b1;
        ser_evt = 3'h7;
        @(negedge clk);
        ser_evt = 3'h0;
        repeat (2) @(negedge clk);
        rd(`PRB_OFS_SER_STS, 16'h0017);
        rd(`PRB_OFS_SER_STS, 16'h0010);
        cts = 1'b0;
        repeat (3) @(negedge clk);
        rd(`PRB_OFS_SER_STS, 16'h0000);
    endtask

    task automatic t_refresh;
        wr(`PRB_OFS_REFRESH, 16'h0100);
        @(negedge clk);
        chk_word(refresh_addr, 16'h0100);
        refresh_done = 1'b1;
        @(negedge clk);
        refresh_done = 1'b0;
        rd(`PRB_OFS_REFRESH, 16'h0101);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        t_reset_vals();
        t_waits();
        t_ports();
        t_mask();
        t_timer_keep();
        t_serial();
        t_status();
        t_refresh();
        end_sim();
    end

    // whole run needs about 120 cycles
    initial
    begin
        repeat (3000) @(posedge clk);
        failures++;
        end_sim();
    end
endmodule
`default_nettype wire
